// >>> inc/cfg_fn1_pkg.sv
// Functional notes
// - Function number bits must equal one
// - Claim only with idsel high, ad[1:0]=00
// - Registers spaced in four-byte steps
// - Configuration cycles answered at all times
// - Burst reads and writes accepted
// - Writes to read-only locations complete, discarded
// - Unimplemented locations and bits read zero
// - Select register by ad[7:2] and byte enables
// - Optional header registers left unimplemented
// - Read/write bits reset to zero
// - Write one clears status bit
// - Identity register read-only, device and maker
// - Command zero blocks non-configuration cycles
// - Unassigned command bits read zero
// - Bit 31 set on any parity error
// - Bit 30 set when system error signalled
// - Bits 29/28 on master or target abort
// - Bit 27 set when target abort signalled
// - Decode timing field reads fixed 01
// - Bit 24 on reported parity, enable gated
// - Bit 23 back-to-back capable reads one
// - Bit 20 capabilities list reads one
// - Command bits enable memory and mastering
// - Command bits enable parity and error driver
`default_nettype none
package cfg_fn1_pkg;
   localparam logic [2:0]  FUNC_NUM          = 3'h1;
   localparam logic [1:0]  CFG_TYPE_BITS     = 2'h0;
   localparam logic [7:0]  OFF_IDENTITY      = 8'h00;
   localparam logic [7:0]  OFF_CMD_STATUS    = 8'h04;
   // Arbitrary neutral identity values
   localparam logic [15:0] DEVICE_CODE       = 16'h0001;
   localparam logic [15:0] MAKER_CODE        = 16'hfffe;
   localparam int          BIT_MEM_EN        = 1;
   localparam int          BIT_MASTER_EN     = 2;
   localparam int          BIT_PARITY_EN     = 6;
   localparam int          BIT_SERR_EN       = 8;
   localparam logic [15:0] CMD_WRITE_MASK    = 16'h0146;
   localparam logic [15:0] CMD_RESET         = 16'h0000;
   localparam logic [15:0] STAT_FIXED        = 16'h0290;
   localparam logic [15:0] STAT_W1C_MASK     = 16'hf900;
   localparam logic [15:0] STAT_RESET        = 16'h0000;
   localparam int          ST_PARITY         = 15;
   localparam int          ST_SERR           = 14;
   localparam int          ST_RX_MABORT      = 13;
   localparam int          ST_RX_TABORT      = 12;
   localparam int          ST_TX_TABORT      = 11;
   localparam int          ST_DATA_PAR       = 8;

   typedef struct packed {
      logic parity_err;
      logic serr_asserted;
      logic master_abort;
      logic target_abort_rx;
      logic target_abort_tx;
      logic perr_reported;
   } bus_events_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] data;
      logic        write;
   } cfg_req_type;
endpackage : cfg_fn1_pkg
`default_nettype wire

// >>> hdl/cfg_fn1_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_fn1_regs
   import cfg_fn1_pkg::*;
(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   // Configuration data phase from the target sequencer
   input  wire logic           cfg_phase,
   input  wire logic           idsel,
   input  wire logic [2:0]     func_sel,
   input  wire logic [1:0]     ad_low,
   input  wire cfg_req_type    req,
   // Bus events from the function
   input  wire bus_events_type events,
   // Results
   output logic                claim_q,
   output logic [31:0]         rdata_q,
   output logic                mem_enable_q,
   output logic                master_enable_q,
   output logic                parity_enable_q,
   output logic                serr_enable_q,
   output logic                bus_active_q
);

   logic [15:0] cmd_q;
   logic [15:0] stat_q;
   logic        hit;
   logic        wr_cmd;

   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // No gating by command state: config space is always reachable
   assign hit = cfg_phase && idsel && (ad_low == CFG_TYPE_BITS)
                && (func_sel == FUNC_NUM);
   // Word index from ad[7:2]; each phase is decoded on its own
   assign wr_cmd = hit && req.write
                   && ({req.addr[7:2], 2'b00} == OFF_CMD_STATUS);

   // Anything short of a full match must leave no trace
   property p_no_claim;
      @(posedge clk) disable iff (!rst_b)
      !hit |=> !claim_q;
   endproperty
   a_no_claim: assert property (p_no_claim)
      else $error("claim without a valid phase");

   property p_no_effect;
      @(posedge clk) disable iff (!rst_b)
      !hit |=> cmd_q == $past(cmd_q);
   endproperty
   a_no_effect: assert property (p_no_effect)
      else $error("ignored cycle changed command");

   property p_burst;
      @(posedge clk) disable iff (!rst_b)
      (hit ##1 hit) |=> claim_q;
   endproperty
   a_burst: assert property (p_burst)
      else $error("second burst phase not claimed");

   // ------------------------------------------------------------
   // Command half
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_q <= CMD_RESET;
      end else if (wr_cmd) begin
         cmd_q <= (cmd_q & ~lane_mask(req.be[1:0]))
                  | (req.data[15:0] & lane_mask(req.be[1:0])
                     & CMD_WRITE_MASK);
      end
   end

   // ------------------------------------------------------------
   // Status half
   // ------------------------------------------------------------
   logic [15:0] set_bits;
   logic [15:0] clr_bits;
   always_comb begin
      set_bits = 16'h0000;
      set_bits[ST_PARITY]    = events.parity_err;
      set_bits[ST_SERR]      = events.serr_asserted;
      set_bits[ST_RX_MABORT] = events.master_abort;
      set_bits[ST_RX_TABORT] = events.target_abort_rx;
      set_bits[ST_TX_TABORT] = events.target_abort_tx;
      set_bits[ST_DATA_PAR]  = events.perr_reported
                               && cmd_q[BIT_PARITY_EN];
      clr_bits = wr_cmd ? (req.data[31:16] & lane_mask(req.be[3:2])
                           & STAT_W1C_MASK) : 16'h0000;
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_q <= STAT_RESET;
      end else begin
         stat_q <= (stat_q & ~clr_bits) | set_bits;
      end
   end

   property p_serr_set;
      @(posedge clk) disable iff (!rst_b)
      events.serr_asserted |=> stat_q[ST_SERR];
   endproperty
   a_serr_set: assert property (p_serr_set)
      else $error("system error status not set");

   property p_mabort_set;
      @(posedge clk) disable iff (!rst_b)
      events.master_abort |=> stat_q[ST_RX_MABORT];
   endproperty
   a_mabort_set: assert property (p_mabort_set)
      else $error("master abort status not set");

   property p_rx_tabort_set;
      @(posedge clk) disable iff (!rst_b)
      events.target_abort_rx |=> stat_q[ST_RX_TABORT];
   endproperty
   a_rx_tabort_set: assert property (p_rx_tabort_set)
      else $error("received target abort status not set");

   property p_tx_tabort_set;
      @(posedge clk) disable iff (!rst_b)
      events.target_abort_tx |=> stat_q[ST_TX_TABORT];
   endproperty
   a_tx_tabort_set: assert property (p_tx_tabort_set)
      else $error("signalled target abort status not set");

   property p_perr_set;
      @(posedge clk) disable iff (!rst_b)
      (events.perr_reported && cmd_q[BIT_PARITY_EN])
      |=> stat_q[ST_DATA_PAR];
   endproperty
   a_perr_set: assert property (p_perr_set)
      else $error("data parity status not set");

   property p_stat_hold;
      @(posedge clk) disable iff (!rst_b)
      (!wr_cmd && events == '0) |=> stat_q == $past(stat_q);
   endproperty
   a_stat_hold: assert property (p_stat_hold)
      else $error("status changed without cause");

   property p_w1c_lanes;
      @(posedge clk) disable iff (!rst_b)
      (wr_cmd && !req.be[3]) |=> ($past(stat_q) & ~stat_q) == 16'h0000;
   endproperty
   a_w1c_lanes: assert property (p_w1c_lanes)
      else $error("status cleared through disabled lane");

   // ------------------------------------------------------------
   // Read path and outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 32'h0000_0000;
         claim_q <= 1'b0;
      end else begin
         claim_q <= hit;
         if (hit && !req.write) begin
            unique case ({req.addr[7:2], 2'b00})
               OFF_IDENTITY:   rdata_q <= {DEVICE_CODE, MAKER_CODE};
               OFF_CMD_STATUS: rdata_q <= {stat_q | STAT_FIXED,
                                           cmd_q};
               default:        rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   property p_cmd_read;
      @(posedge clk) disable iff (!rst_b)
      (hit && !req.write && req.addr[7:2] == 6'h01)
      |=> (rdata_q[15:0] & ~CMD_WRITE_MASK) == 16'h0000;
   endproperty
   a_cmd_read: assert property (p_cmd_read)
      else $error("unassigned command bit read one");

   property p_stat_reserved;
      @(posedge clk) disable iff (!rst_b)
      (hit && !req.write && req.addr[7:2] == 6'h01)
      |=> (rdata_q[31:16] & ~(STAT_W1C_MASK | STAT_FIXED)) == 16'h0000;
   endproperty
   a_stat_reserved: assert property (p_stat_reserved)
      else $error("reserved status bit read one");

   property p_ro_write;
      @(posedge clk) disable iff (!rst_b)
      (hit && req.write && req.addr[7:2] != 6'h01)
      |=> cmd_q == $past(cmd_q) && ($past(stat_q) & ~stat_q) == 16'h0000;
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("write to read-only location took effect");

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_enable_q    <= 1'b0;
         master_enable_q <= 1'b0;
         parity_enable_q <= 1'b0;
         serr_enable_q   <= 1'b0;
         bus_active_q    <= 1'b0;
      end else begin
         mem_enable_q    <= cmd_q[BIT_MEM_EN];
         master_enable_q <= cmd_q[BIT_MASTER_EN];
         parity_enable_q <= cmd_q[BIT_PARITY_EN];
         serr_enable_q   <= cmd_q[BIT_SERR_EN];
         bus_active_q    <= |cmd_q;
      end
   end

   // Enables trail the command write by one more clock
   property p_mem_en;
      @(posedge clk) disable iff (!rst_b)
      (wr_cmd && req.be[0])
      |=> ##1 mem_enable_q == $past(req.data[BIT_MEM_EN], 2);
   endproperty
   a_mem_en: assert property (p_mem_en)
      else $error("memory enable does not follow write");

   property p_master_en;
      @(posedge clk) disable iff (!rst_b)
      (wr_cmd && req.be[0])
      |=> ##1 master_enable_q == $past(req.data[BIT_MASTER_EN], 2);
   endproperty
   a_master_en: assert property (p_master_en)
      else $error("master enable does not follow write");

   property p_parity_en;
      @(posedge clk) disable iff (!rst_b)
      (wr_cmd && req.be[0])
      |=> ##1 parity_enable_q == $past(req.data[BIT_PARITY_EN], 2);
   endproperty
   a_parity_en: assert property (p_parity_en)
      else $error("parity enable does not follow write");

   property p_serr_en;
      @(posedge clk) disable iff (!rst_b)
      (wr_cmd && req.be[1])
      |=> ##1 serr_enable_q == $past(req.data[BIT_SERR_EN], 2);
   endproperty
   a_serr_en: assert property (p_serr_en)
      else $error("error driver enable does not follow write");

   property p_active_on;
      @(posedge clk) disable iff (!rst_b)
      (cmd_q != 16'h0000) |=> bus_active_q;
   endproperty
   a_active_on: assert property (p_active_on)
      else $error("inactive with nonzero command");

   property p_cmd_zero_idle;
      @(posedge clk) disable iff (!rst_b)
      (cmd_q == 16'h0000) |=> !mem_enable_q && !master_enable_q;
   endproperty
   a_cmd_zero_idle: assert property (p_cmd_zero_idle)
      else $error("enabled with zero command");

   property p_reset_vals;
      @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> cmd_q == CMD_RESET && stat_q == STAT_RESET;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("register not cleared by reset");

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_claim_func;
      @(posedge clk) disable iff (!rst_b)
      (cfg_phase && func_sel != FUNC_NUM) |=> !claim_q;
   endproperty
   a_claim_func: assert property (p_claim_func)
      else $error("claimed other function");

   property p_claim_ok;
      @(posedge clk) disable iff (!rst_b)
      (cfg_phase && idsel && ad_low == 2'b00 && func_sel == FUNC_NUM)
      |=> claim_q;
   endproperty
   a_claim_ok: assert property (p_claim_ok)
      else $error("valid config cycle not claimed");

   property p_id_read;
      @(posedge clk) disable iff (!rst_b)
      (hit && !req.write && req.addr[7:2] == 6'h00)
      |=> rdata_q == {DEVICE_CODE, MAKER_CODE};
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("identity read wrong");

   property p_unimpl_zero;
      @(posedge clk) disable iff (!rst_b)
      (hit && !req.write && req.addr[7:2] > 6'h01)
      |=> rdata_q == 32'h0000_0000;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("unimplemented read not zero");

   property p_fixed_bits;
      @(posedge clk) disable iff (!rst_b)
      (hit && !req.write && req.addr[7:2] == 6'h01)
      |=> rdata_q[26:25] == 2'b01 && rdata_q[23] && rdata_q[20];
   endproperty
   a_fixed_bits: assert property (p_fixed_bits)
      else $error("fixed status bits wrong");

   property p_parity_set;
      @(posedge clk) disable iff (!rst_b)
      events.parity_err |=> stat_q[ST_PARITY];
   endproperty
   a_parity_set: assert property (p_parity_set)
      else $error("parity status not set");

   property p_w1c;
      @(posedge clk) disable iff (!rst_b)
      (wr_cmd && req.be[3] && req.data[31] && !events.parity_err)
      |=> !stat_q[ST_PARITY];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("write one did not clear");

   property p_w0_keep;
      @(posedge clk) disable iff (!rst_b)
      (stat_q[ST_SERR] && !(wr_cmd && req.be[3] && req.data[30]))
      |=> stat_q[ST_SERR];
   endproperty
   a_w0_keep: assert property (p_w0_keep)
      else $error("status bit lost");

   property p_perr_gate;
      @(posedge clk) disable iff (!rst_b)
      (events.perr_reported && !cmd_q[BIT_PARITY_EN]
       && !stat_q[ST_DATA_PAR]) |=> !stat_q[ST_DATA_PAR];
   endproperty
   a_perr_gate: assert property (p_perr_gate)
      else $error("data parity set while disabled");

   property p_cmd_unused;
      @(posedge clk) disable iff (!rst_b)
      (cmd_q & ~CMD_WRITE_MASK) == 16'h0000;
   endproperty
   a_cmd_unused: assert property (p_cmd_unused)
      else $error("unused command bit set");

   property p_be_lane;
      @(posedge clk) disable iff (!rst_b)
      (wr_cmd && !req.be[1]) |=> cmd_q[15:8] == $past(cmd_q[15:8]);
   endproperty
   a_be_lane: assert property (p_be_lane)
      else $error("disabled byte lane written");

   property p_active;
      @(posedge clk) disable iff (!rst_b)
      (cmd_q == 16'h0000) |=> !bus_active_q;
   endproperty
   a_active: assert property (p_active)
      else $error("active with zero command");

endmodule : cfg_fn1_regs
`default_nettype wire

// >>> testbench/host_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bridge_model
   import cfg_fn1_pkg::*;
(
   // Clock
   input  wire logic         clk,
   // Configuration phase to the function
   output var  logic         cfg_phase,
   output var  logic         idsel,
   output var  logic [2:0]   func_sel,
   output var  logic [1:0]   ad_low,
   output var  cfg_req_type  req
);
   initial begin
      cfg_phase = 1'b0;
      idsel     = 1'b0;
      func_sel  = 3'h0;
      ad_low    = 2'h3;
      req       = '0;
   end

   // One data phase, held until the next phase or a release;
   // sel is {idsel, function, ad[1:0]}
   task automatic phase(input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, input logic w,
                        input logic [5:0] sel = 6'h24);
      @(posedge clk);
      cfg_phase <= 1'b1;
      {idsel, func_sel, ad_low} <= sel;
      req <= '{addr: a, be: be, data: d, write: w};
   endtask : phase

   // Released lines invert so stale data can never look valid
   task automatic release_bus();
      @(posedge clk);
      cfg_phase <= 1'b0;
      idsel     <= ~idsel;
      req       <= ~req;
   endtask : release_bus
endmodule : host_bridge_model
`default_nettype wire

// >>> testbench/cfg_fn1_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_fn1_regs_test
   import cfg_fn1_pkg::*;
;
   logic           clk = 1'b0;
   logic           rst_b = 1'b0;
   logic           cfg_phase, idsel, claim_q, active;
   logic           mem_en, mst_en, par_en, serr_en;
   logic [2:0]     func_sel;
   logic [1:0]     ad_low;
   logic [31:0]    rdata_q;
   cfg_req_type    req;
   bus_events_type events = '0;
   int             miscompares = 0;
   int             samples_checked = 0;
   logic [7:0]     holes [8] = '{8'h08, 8'h0c, 8'h10, 8'h2c,
                                 8'h34, 8'h3c, 8'h40, 8'hfc};
   logic [5:0]     bad [3] = '{6'h2c, 6'h04, 6'h25};

   always #2 clk = ~clk;

   host_bridge_model u_host (.clk(clk), .cfg_phase(cfg_phase),
      .idsel(idsel), .func_sel(func_sel), .ad_low(ad_low), .req(req));
   cfg_fn1_regs u_dut (.clk(clk), .rst_b(rst_b), .cfg_phase(cfg_phase),
      .idsel(idsel), .func_sel(func_sel), .ad_low(ad_low), .req(req),
      .events(events), .claim_q(claim_q), .rdata_q(rdata_q),
      .mem_enable_q(mem_en), .master_enable_q(mst_en),
      .parity_enable_q(par_en), .serr_enable_q(serr_en),
      .bus_active_q(active));

   // ----
   // Access tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      u_host.phase(a, 4'hf, 32'h0, 1'b0);
      u_host.release_bus();
      #1;
      check(claim_q, 1'b1);
      check(rdata_q, exp);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      u_host.phase(a, be, d, 1'b1);
      u_host.release_bus();
      #1;
      check(claim_q, 1'b1);
   endtask : wr

   task automatic pulse(input bus_events_type ev);
      @(posedge clk);
      events <= ev;
      @(posedge clk);
      events <= '0;
   endtask : pulse

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude

   // ----
   // Tests
   // ----
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h04, 32'h0290_0000);
      check(active, 1'b0);
      rd(8'h00, {DEVICE_CODE, MAKER_CODE});
      wr(8'h00, 4'hf, 32'hffff_ffff);
      rd(8'h00, {DEVICE_CODE, MAKER_CODE});
      foreach (holes[i]) rd(holes[i], 32'h0);
      $display("test identity and holes finished");
      foreach (bad[i]) begin
         u_host.phase(8'h04, 4'hf, 32'hffff_ffff, 1'b1, bad[i]);
         u_host.release_bus();
         #1;
         check(claim_q, 1'b0);
      end
      rd(8'h04, 32'h0290_0000);
      $display("test refusals finished");
      wr(8'h04, 4'h1, 32'hffff_ffff);
      rd(8'h04, 32'h0290_0046);
      check({mem_en, mst_en, par_en, serr_en}, 4'he);
      // Burst: write then read in adjacent phases
      u_host.phase(8'h04, 4'h3, 32'hffff_ffff, 1'b1);
      u_host.phase(8'h04, 4'hf, 32'h0, 1'b0);
      u_host.release_bus();
      #1;
      check(rdata_q, 32'h0290_0146);
      check({mem_en, mst_en, par_en, serr_en, active}, 5'h1f);
      $display("test command finished");
      pulse('1);
      rd(8'h04, 32'hfb90_0146);
      wr(8'h04, 4'h4, 32'hffff_0000);
      rd(8'h04, 32'hfb90_0146);
      wr(8'h04, 4'h8, 32'h7f00_0000);
      rd(8'h04, 32'h8290_0146);
      wr(8'h04, 4'h8, 32'h0);
      rd(8'h04, 32'h8290_0146);
      wr(8'h04, 4'hb, 32'h8000_0000);
      rd(8'h04, 32'h0290_0000);
      check(active, 1'b0);
      pulse('{parity_err: 1'b1, perr_reported: 1'b1, default: 1'b0});
      rd(8'h04, 32'h8290_0000);
      // One event at a time, so a swapped bit position shows
      pulse('{serr_asserted: 1'b1, default: 1'b0});
      rd(8'h04, 32'hc290_0000);
      pulse('{master_abort: 1'b1, default: 1'b0});
      rd(8'h04, 32'he290_0000);
      pulse('{target_abort_rx: 1'b1, default: 1'b0});
      rd(8'h04, 32'hf290_0000);
      pulse('{target_abort_tx: 1'b1, default: 1'b0});
      rd(8'h04, 32'hfa90_0000);
      $display("test status finished");
      conclude();
   end

   initial begin
      #4000;
      miscompares++;
      conclude();
   end
endmodule : cfg_fn1_regs_test
`default_nettype wire
